// ===== verilog/seq_stamp_pkg.sv
package seq_stamp_pkg;
   localparam int          NUM_CH           = 2;
   localparam int          STAMP_W          = 16;
   localparam logic [7:0]  CH3_STAMP_HIGH   = 8'h94;
   localparam logic [7:0]  CH3_STAMP_LOW    = 8'h95;
   localparam logic [7:0]  CH4_STAMP_HIGH   = 8'h96;
   localparam logic [7:0]  CH4_STAMP_LOW    = 8'h97;
   localparam logic [15:0] STAMP_RESET      = 16'h0000;
   localparam logic [1:0]  SEQ_CODE_ON      = 2'h1;
   localparam logic [1:0]  SEQ_CODE_OFF     = 2'h2;
   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          STAMP_PERIOD_NS  = 50000;
   localparam int          STAMP_PERIOD_CYC = STAMP_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [7:0]  RD_UNMAPPED      = 8'h00;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ON, SEQ_OFF} seq_state_t;
endpackage : seq_stamp_pkg

// ===== verilog/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
   #(parameter int W = 1)
   (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
   );
   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_q;

   always_comb
   begin
      next_stage1 = rst ? '0 : d;
      next_q      = rst ? '0 : stage1;
   end

   always_ff @(posedge clk)
   begin
      stage1 <= next_stage1;
      q      <= next_q;
   end
endmodule : pin_sync

// ===== verilog/sequence_timestamp_capture.sv
// Overview of operation
// R1: Timer runs during a sequence started by power-sequence control or sleep field; here only SEQ_START with code 01 or 10 starts one.
// R2: Code 01 sequences latch stamp when rising rail crosses low undervoltage threshold.
// R3: Code 10 sequences latch stamp when falling rail drops below 200mV off level.
// R4: Timer advances one count every 50us of sequence time.
// R5: Channel 3 stamp reads as high byte at 94h, low byte at 95h.
// R6: Channel 4 stamp reads as high byte at 96h, low byte at 97h.
// R7: Both bytes of a stamp update together in one capture.
`timescale 1ns/10ps
module sequence_timestamp_capture
   import seq_stamp_pkg::*;
   (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        SEQ_START,
   input  wire logic [1:0]  POWER_SEQUENCE_CONTROL,
   input  wire logic        SEQ_DONE,
   input  wire logic [1:0]  ABOVE_LOW_UNDERVOLTAGE_THRESHOLD,
   input  wire logic [1:0]  ABOVE_OFF_LEVEL,
   input  wire logic [7:0]  RD_ADDR,
   output logic      [7:0]  RD_DATA,
   output logic             SEQ_ACTIVE,
   output logic      [1:0]  STAMP_VALID
   );
   // Comparator levels cross from the analog side, so each group gets two stages
   logic [1:0] uv_sync;
   logic [1:0] off_sync;

   pin_sync #(.W(2)) i_uv_sync
   (
      .clk (CLK),
      .rst (RST),
      .d   (ABOVE_LOW_UNDERVOLTAGE_THRESHOLD),
      .q   (uv_sync)
   );

   // Off level idles high; resetting its history low avoids a false falling edge
   pin_sync #(.W(2)) i_off_sync
   (
      .clk (CLK),
      .rst (RST),
      .d   (ABOVE_OFF_LEVEL),
      .q   (off_sync)
   );

   seq_state_t        state;
   seq_state_t        next_state;
   logic [15:0]       prescale;
   logic [15:0]       next_prescale;
   logic [15:0]       timer;
   logic [15:0]       next_timer;
   logic [1:0]        uv_prev;
   logic [1:0]        off_prev;
   logic [1:0]        captured;
   logic [1:0]        next_captured;
   logic [15:0]       stamp      [NUM_CH];
   logic [15:0]       next_stamp [NUM_CH];
   logic [1:0]        hit;
   logic [7:0]        next_rd_data;
   logic [1:0]        next_uv_prev;
   logic [1:0]        next_off_prev;
   logic              next_seq_active;
   logic              tick;

   function automatic logic [7:0] read_mux(input logic [7:0] a,
                                           input logic [15:0] s3,
                                           input logic [15:0] s4);
      logic [7:0] r;
      r = RD_UNMAPPED;
      unique case (a)
         CH3_STAMP_HIGH: r = s3[15:8]; // R5
         CH3_STAMP_LOW:  r = s3[7:0];  // R5
         CH4_STAMP_HIGH: r = s4[15:8]; // R6
         CH4_STAMP_LOW:  r = s4[7:0];  // R6
         default:        r = RD_UNMAPPED;
      endcase
      return r;
   endfunction : read_mux

   // A start with an unused code is dropped entirely, capture flags included
   function automatic logic starts_sequence(input seq_state_t s,
                                            input logic       start,
                                            input logic [1:0] code);
      return (s == SEQ_IDLE) && start && (code == SEQ_CODE_ON || code == SEQ_CODE_OFF);
   endfunction : starts_sequence

   // Direction of the crossing that counts depends on the kind of sequence
   function automatic logic crossing(input seq_state_t s,
                                     input logic       uv_now,
                                     input logic       uv_last,
                                     input logic       off_now,
                                     input logic       off_last);
      logic c;
      c = 1'b0;
      if (s == SEQ_ON)
         c = uv_now && !uv_last; // R2
      else if (s == SEQ_OFF)
         c = !off_now && off_last; // R3
      return c;
   endfunction : crossing

   always_comb
   begin
      next_state = state;
      unique case (state)
         SEQ_IDLE:
         begin
            if (starts_sequence(state, SEQ_START, POWER_SEQUENCE_CONTROL))
               next_state = (POWER_SEQUENCE_CONTROL == SEQ_CODE_ON) ? SEQ_ON : SEQ_OFF; // R1
         end
         SEQ_ON, SEQ_OFF:
         begin
            if (SEQ_DONE)
               next_state = SEQ_IDLE;
         end
      endcase
      if (RST)
         next_state = SEQ_IDLE;
   end

   always_ff @(posedge CLK)
   begin
      state <= next_state;
   end

   // Prescaler divides the clock down to one timer count per stamp period
   assign tick = (prescale == 16'(STAMP_PERIOD_CYC - 1)); // R4

   always_comb
   begin
      next_prescale = 16'h0000;
      next_timer    = 16'h0000;
      if (state != SEQ_IDLE)
      begin
         next_prescale = tick ? 16'h0000 : prescale + 16'h0001;
         next_timer    = timer;
         // Timer saturates rather than wrapping so a late crossing never looks early
         if (tick && timer != 16'hffff)
            next_timer = timer + 16'h0001; // R4
      end
      if (RST)
      begin
         next_prescale = 16'h0000;
         next_timer    = 16'h0000;
      end
   end

   always_ff @(posedge CLK)
   begin
      prescale <= next_prescale;
      timer    <= next_timer;
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         always_comb
         begin
            hit[g] = crossing(state, uv_sync[g], uv_prev[g], off_sync[g], off_prev[g]); // R2 R3
            next_stamp[g]    = stamp[g];
            next_captured[g] = captured[g];
            if (starts_sequence(state, SEQ_START, POWER_SEQUENCE_CONTROL))
               next_captured[g] = 1'b0;
            // First crossing only; bounce on the rail cannot overwrite it
            if (hit[g] && !captured[g])
            begin
               next_stamp[g]    = timer; // R7
               next_captured[g] = 1'b1;
            end
            if (RST)
            begin
               next_stamp[g]    = STAMP_RESET;
               next_captured[g] = 1'b0;
            end
         end

         always_ff @(posedge CLK)
         begin
            stamp[g]    <= next_stamp[g];
            captured[g] <= next_captured[g];
         end
      end
   endgenerate

   // Reads have no side effect; a high/low pair stays coherent since capture writes both
   always_comb
   begin
      next_uv_prev    = uv_sync;
      next_off_prev   = off_sync;
      next_rd_data    = read_mux(RD_ADDR, stamp[0], stamp[1]);
      next_seq_active = (next_state != SEQ_IDLE); // R1
      if (RST)
      begin
         next_uv_prev    = 2'h0;
         next_off_prev   = 2'h0;
         next_rd_data    = RD_UNMAPPED;
         next_seq_active = 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      uv_prev     <= next_uv_prev;
      off_prev    <= next_off_prev;
      RD_DATA     <= next_rd_data;
      SEQ_ACTIVE  <= next_seq_active;
      STAMP_VALID <= next_captured; // R2 R3
   end
endmodule : sequence_timestamp_capture

// ===== bench/seq_stamp_checker.sv
`timescale 1ns/10ps
module seq_stamp_checker
   (
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic       SEQ_START,
   input wire logic [1:0] POWER_SEQUENCE_CONTROL,
   input wire logic       SEQ_DONE,
   input wire logic [7:0] RD_ADDR,
   input wire logic [7:0] RD_DATA,
   input wire logic       SEQ_ACTIVE,
   input wire logic [1:0] STAMP_VALID
   );
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_start; SEQ_START && !SEQ_ACTIVE && POWER_SEQUENCE_CONTROL inside {2'h1, 2'h2}; endsequence
   sequence s_bad_start; SEQ_START && !SEQ_ACTIVE && POWER_SEQUENCE_CONTROL inside {2'h0, 2'h3}; endsequence
   property p_go; s_start |=> SEQ_ACTIVE; endproperty
   a_go: assert property (p_go) else $error("sequence did not start");
   property p_end; SEQ_ACTIVE && SEQ_DONE |=> !SEQ_ACTIVE; endproperty
   a_end: assert property (p_end) else $error("sequence did not end");
   property p_map; !(RD_ADDR inside {[8'h94:8'h97]}) |=> RD_DATA == 8'h00; endproperty
   a_map: assert property (p_map) else $error("unmapped read not zero");
   property p_clear; s_start |=> STAMP_VALID == 2'h0; endproperty
   a_clear: assert property (p_clear) else $error("capture flags not cleared at start");
   property p_ignore; s_bad_start |=> !SEQ_ACTIVE; endproperty
   a_ignore: assert property (p_ignore) else $error("unused code started a sequence");
   property p_keep; !SEQ_START |=> (STAMP_VALID & $past(STAMP_VALID)) == $past(STAMP_VALID); endproperty
   a_keep: assert property (p_keep) else $error("capture flag dropped mid sequence");
endmodule : seq_stamp_checker
bind sequence_timestamp_capture seq_stamp_checker i_seq_stamp_checker (.CLK(CLK), .RST(RST), .SEQ_START(SEQ_START),
   .POWER_SEQUENCE_CONTROL(POWER_SEQUENCE_CONTROL), .SEQ_DONE(SEQ_DONE), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
   .SEQ_ACTIVE(SEQ_ACTIVE), .STAMP_VALID(STAMP_VALID));

// ===== bench/sequence_timestamp_capture_tb_top.sv
`timescale 1ns/10ps
module sequence_timestamp_capture_tb_top;
   logic        clk, rst, start, done, active;
   logic [1:0]  code, rail, valid;
   logic [7:0]  addr, data;
   logic [31:0] lfsr;
   logic [15:0] k3, k4;
   int          num_errors, checks, cycles;
   sequence_timestamp_capture i_sequence_timestamp_capture (.CLK(clk), .RST(rst), .SEQ_START(start),
      .POWER_SEQUENCE_CONTROL(code), .SEQ_DONE(done), .ABOVE_LOW_UNDERVOLTAGE_THRESHOLD(rail),
      .ABOVE_OFF_LEVEL(rail), .RD_ADDR(addr), .RD_DATA(data), .SEQ_ACTIVE(active), .STAMP_VALID(valid));
   function automatic logic [31:0] step(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h80200003 : 32'h0);
   endfunction : step
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      logic [15:0] s;
      s = a[1] ? k4 : k3;
      return (a inside {[8'h94:8'h97]}) ? (a[0] ? s[7:0] : s[15:8]) : 8'h00;
   endfunction : exp_rd
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      num_errors += int'(got !== exp);
      if (got !== exp)
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
   endtask : chk
   task automatic complete_run;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run
   task automatic rd;
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clk) addr <= 8'h94 + 8'(i);
         @(posedge clk);
         #1 chk(16'(data), 16'(exp_rd(addr)));
      end
   endtask : rd
   // Crossings sit mid-period so the expected count never hinges on the exact tick edge
   task automatic run(input logic [1:0] c);
      lfsr = step(lfsr);
      k3 = 16'(lfsr[0]);
      k4 = k3 + 16'(lfsr[1]) + 16'h1;
      @(posedge clk) start <= 1'b1;
      code <= c;
      @(posedge clk) start <= 1'b0;
      repeat (5000 * k3 + 2500) @(posedge clk);
      rail[0] <= c[0];
      repeat (5000 * (k4 - k3) - 20) @(posedge clk);
      rail[0] <= ~c[0];
      repeat (20) @(posedge clk);
      rail <= {2{c[0]}};
      repeat (8) @(posedge clk);
      #1 chk(16'(active), 16'h1);
      @(posedge clk) done <= 1'b1;
      @(posedge clk) done <= 1'b0;
      @(posedge clk) #1 chk(16'(valid), 16'h3);
      chk(16'(active), 16'h0);
      rd;
   endtask : run
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Four sequences of at most about 18k cycles each sit well under the ceiling
   initial
   begin
      cycles = 0;
      while (cycles < 90000)
         @(posedge clk) cycles++;
      num_errors++;
      complete_run;
   end
   initial
   begin
      rst = 1'b1;
      {start, done, code, rail, addr, k3, k4} = '0;
      lfsr = 32'h425e;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd;
      @(posedge clk) code <= 2'h3;
      start <= 1'b1;
      @(posedge clk) start <= 1'b0;
      @(posedge clk) #1 chk(16'(active), 16'h0);
      for (int i = 0; i < 4; i++)
         run(i[0] ? 2'h2 : 2'h1);
      complete_run;
   end
endmodule : sequence_timestamp_capture_tb_top
